// *** inc/npic_pkg.sv ***
package npic_pkg;
	// Two-bit level codes held in the condition-code priority bits
	localparam logic [1:0] LVL0_CODE = 2'h2;
	localparam logic [1:0] LVL1_CODE = 2'h1;
	localparam logic [1:0] LVL2_CODE = 2'h0;
	localparam logic [1:0] LVL3_CODE = 2'h3;
	// Positions of the priority bits in the condition-code register
	localparam int LEVEL_BIT_UPPER_POS = 5;
	localparam int LEVEL_BIT_LOWER_POS = 3;
	localparam logic [7:0] CC_RESET = 8'hea;
	// Vector numbering: 0 is the top-level pin, 1..13 maskable
	localparam int NUM_VECTORS = 14;
	localparam logic [15:0] VEC_RESET = 16'hfffe;
	localparam logic [15:0] VEC_TRAP = 16'hfffc;
	localparam logic [15:0] VEC_TOP = 16'hfffa;
	localparam logic [7:0] LEVEL_REGS_RESET = 8'hff;
	// Register indices of the four per-vector level registers
	localparam logic [1:0] LEVEL_REG0 = 2'h0;
	localparam logic [1:0] LEVEL_REG3 = 2'h3;
	// Default halt-exit capability per vector (bit n = vector n)
	localparam logic [13:0] HALT_WAKE_MASK = 14'h20bf;
	// Default external-line vectors (edge latched, auto-cleared)
	localparam logic [13:0] EXT_MASK = 14'h003c;
	// Number of stacked bytes: PCH, PCL, X, A, CC
	localparam logic [2:0] STACK_BYTES = 3'h5;
	typedef enum logic [1:0] {SRC_RESET, SRC_TRAP, SRC_TOP, SRC_MASK} npic_src_t;
endpackage

// *** verilog/npic_ctrl.sv ***
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
// Summary of operation
// R1: Level codes 10,01,00,11 in condition bits
// R2: Finish current instruction before taking request
// R3: Stack PC, X, A, condition register
// R4: Load priority bits from vector level
// R5: Load PC from fixed vector after stacking
// R6: Return restores stacked priority bits
// R7: Highest software level, then hardware priority
// R8: Unserviced requests stay latched until winning
// R9: Pin event, reset, trap rank top level
// R10: Reset and trap unmasked, set level 3
// R11: Reset and trap leave halt mode
// R12: Trap serviced on instruction; pin preempts
// R13: Reset highest in both priorities
// R14: Maskable needs enable and higher level
// R15: Pin edge raises top request, like trap
// R16: External edges latched, cleared on entry
// R17: Shared external line ORs enabled pins
// R18: Peripheral request needs flag and enable
// R19: Flag clearing sequence drops pending latch
// R20: Any request ends wait; selected end halt
// R21: Halt exit picks among halt-capable only
// R22: Unique hardware order; equal level not preempting
// R23: Writes of level-0 code are ignored per field
// R24: Arbitrate and present vector at boundaries
module npic_ctrl #(
	parameter int EXT_PINS = 4,
	parameter logic [13:0] HALT_WAKE = npic_pkg::HALT_WAKE_MASK,
	parameter logic [13:0] EXT_LINES = npic_pkg::EXT_MASK
) (
	input wire logic clk,
	input wire logic reset,
	// Level register port
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// External pins and peripheral flags
	input wire logic top_level_pin_irq,
	input wire logic top_edge_rising,
	input wire logic [EXT_PINS-1:0] ext_pin [4],
	input wire logic [EXT_PINS-1:0] ext_pin_en [4],
	input wire logic [4:0] ext_irq_sensitivity_ctrl,
	input wire logic [13:0] periph_flag,
	input wire logic [13:0] periph_en,
	input wire logic [13:0] periph_clear,
	// CPU sequencer side
	input wire logic instr_boundary,
	input wire logic trap_exec,
	input wire logic return_from_isr,
	input wire logic [7:0] stack_cc,
	input wire logic cc_sw_load,
	input wire logic [7:0] cc_sw_value,
	input wire logic push_ready,
	input wire logic wait_mode,
	input wire logic halt_mode,
	output logic [7:0] condition_code_reg,
	output logic take_irq,
	output logic [15:0] program_counter,
	output logic push_en,
	output logic [2:0] push_sel,
	output logic service_busy,
	output logic wake
);
	// ************************************************************
	// Level registers
	// ************************************************************
	logic [7:0] vector_level_regs [4];
	logic [1:0] cur_code;
	logic [13:0] pend;
	logic reset_pend, trap_pend, top_pend;
	logic [EXT_PINS-1:0] ext_q1 [4];
	logic [EXT_PINS-1:0] ext_q2 [4];
	logic [EXT_PINS-1:0] ext_q3 [4];
	logic top_q1, top_q2, top_q3;

	// Map a two-bit code to a numeric rank 0..3
	function automatic logic [1:0] code_rank(input logic [1:0] c);
		case (c)
			npic_pkg::LVL0_CODE: code_rank = 2'h0; // R1
			npic_pkg::LVL1_CODE: code_rank = 2'h1;
			npic_pkg::LVL2_CODE: code_rank = 2'h2;
			default: code_rank = 2'h3;
		endcase
	endfunction

	// Field-wise merge keeps old field where level-0 is written
	function automatic logic [7:0] merge_level(input logic [7:0] old_v, input logic [7:0] new_v);
		logic [7:0] r;
		r = new_v;
		for (int i = 0; i < 4; i++) begin
			if (new_v[2*i+:2] == npic_pkg::LVL0_CODE) begin
				r[2*i+:2] = old_v[2*i+:2]; // R23
			end
		end
		merge_level = r;
	endfunction

	// Level registers: top nibble of the last one is fixed high
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < 4; i++) begin
				vector_level_regs[i] <= npic_pkg::LEVEL_REGS_RESET;
			end
		end else if (wr) begin
			vector_level_regs[addr] <= merge_level(vector_level_regs[addr], wdata); // R23
			if (addr == npic_pkg::LEVEL_REG3) begin
				vector_level_regs[addr][7:4] <= 4'hf;
			end
		end
	end

	// Read data stands one cycle after the strobe
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata <= 8'h00;
		end else if (rd) begin
			rdata <= vector_level_regs[addr];
		end else begin
			rdata <= 8'h00;
		end
	end

	// ************************************************************
	// Request latching
	// ************************************************************
	// Pins cross into the clock domain through two flops first
	always_ff @(posedge clk) begin
		if (reset) begin
			top_q1 <= 1'b0;
			top_q2 <= 1'b0;
			top_q3 <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				ext_q1[i] <= '0;
				ext_q2[i] <= '0;
				ext_q3[i] <= '0;
			end
		end else begin
			top_q1 <= top_level_pin_irq;
			top_q2 <= top_q1;
			top_q3 <= top_q2;
			for (int i = 0; i < 4; i++) begin
				ext_q1[i] <= ext_pin[i];
				ext_q2[i] <= ext_q1[i];
				ext_q3[i] <= ext_q2[i];
			end
		end
	end

	logic top_edge;
	logic [3:0] ext_edge;
	// Selected edge per group; pins of one group are ORed
	always_comb begin
		top_edge = top_edge_rising ? (top_q2 & ~top_q3) : (~top_q2 & top_q3); // R15
		for (int i = 0; i < 4; i++) begin
			ext_edge[i] = ext_irq_sensitivity_ctrl[i] ?
				|(ext_q2[i] & ~ext_q3[i] & ext_pin_en[i]) :
				|(~ext_q2[i] & ext_q3[i] & ext_pin_en[i]); // R17
		end
	end

	npic_pkg::npic_src_t sel_src;
	npic_pkg::npic_src_t next_src;
	logic [3:0] sel_vec;
	logic [3:0] best_vec;
	logic entering;
	// Pending latches: new events win over the entry clear
	always_ff @(posedge clk) begin
		if (reset) begin
			pend <= '0;
		end else begin
			for (int v = 1; v < npic_pkg::NUM_VECTORS; v++) begin
				if (EXT_LINES[v]) begin
					if (ext_edge[2'(v - 2)]) begin
						pend[v] <= 1'b1; // R8 R16
					end else if (entering && next_src == npic_pkg::SRC_MASK && best_vec == 4'(v)) begin
						pend[v] <= 1'b0; // R16
					end
				end else if (periph_clear[v]) begin
					pend[v] <= 1'b0; // R19
				end else begin
					pend[v] <= periph_flag[v] & periph_en[v]; // R18
				end
			end
			pend[0] <= 1'b0;
		end
	end

	// Top-level, trap and reset latches
	always_ff @(posedge clk) begin
		if (reset) begin
			reset_pend <= 1'b1; // R13
			trap_pend <= 1'b0;
			top_pend <= 1'b0;
		end else begin
			if (entering && next_src == npic_pkg::SRC_RESET) begin
				reset_pend <= 1'b0;
			end
			if (trap_exec) begin
				trap_pend <= 1'b1; // R12
			end else if (entering && next_src == npic_pkg::SRC_TRAP) begin
				trap_pend <= 1'b0;
			end
			if (top_edge) begin
				top_pend <= 1'b1; // R15
			end else if (entering && next_src == npic_pkg::SRC_TOP) begin
				top_pend <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Arbitration
	// ************************************************************
	logic [1:0] cur_rank;
	logic found;
	logic [1:0] best_rank;
	logic [1:0] best_code;
	logic halted;
	// Lowest vector number wins ties: it has the higher hardware rank
	always_comb begin
		logic [1:0] c;
		c = 2'h0;
		cur_rank = code_rank(cur_code);
		found = 1'b0;
		best_rank = 2'h0;
		best_vec = 4'h0;
		best_code = npic_pkg::LVL0_CODE;
		for (int v = npic_pkg::NUM_VECTORS - 1; v >= 1; v--) begin
			c = vector_level_regs[v/4][2*(v%4)+:2];
			if (pend[v] && (!halted || HALT_WAKE[v]) && code_rank(c) > cur_rank) begin // R14 R21
				if (!found || code_rank(c) >= best_rank) begin // R7 R22
					found = 1'b1;
					best_rank = code_rank(c);
					best_vec = 4'(v);
					best_code = c;
				end
			end
		end
	end

	logic next_any;
	// Reset, then pin, then trap rank above all maskable levels
	always_comb begin
		next_any = 1'b1;
		next_src = npic_pkg::SRC_MASK;
		if (reset_pend) begin
			next_src = npic_pkg::SRC_RESET; // R13
		end else if (top_pend) begin
			next_src = npic_pkg::SRC_TOP; // R9 R12
		end else if (trap_pend) begin
			next_src = npic_pkg::SRC_TRAP; // R10
		end else begin
			next_any = found;
		end
	end

	// ************************************************************
	// Entry sequencer
	// ************************************************************
	typedef enum logic [1:0] {NPIC_IDLE, NPIC_PUSH, NPIC_LOAD} npic_state_t;
	npic_state_t state;
	logic [2:0] push_cnt;
	logic [1:0] sel_code;
	// Sample the winner only at an instruction boundary
	assign entering = (state == NPIC_IDLE) && instr_boundary && next_any; // R2 R24
	assign halted = halt_mode;

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= NPIC_IDLE;
			sel_src <= npic_pkg::SRC_RESET;
			sel_vec <= 4'h0;
			sel_code <= npic_pkg::LVL3_CODE;
			push_cnt <= 3'h0;
		end else begin
			case (state)
				NPIC_IDLE: begin
					if (entering) begin
						sel_src <= next_src; // R24
						sel_vec <= best_vec;
						sel_code <= (next_src == npic_pkg::SRC_MASK) ? best_code : npic_pkg::LVL3_CODE;
						push_cnt <= 3'h0;
						// Reset skips stacking
						state <= (next_src == npic_pkg::SRC_RESET) ? NPIC_LOAD : NPIC_PUSH; // R10
					end
				end
				NPIC_PUSH: begin
					if (push_ready) begin
						push_cnt <= push_cnt + 3'h1; // R3
						if (push_cnt == npic_pkg::STACK_BYTES - 3'h1) begin
							state <= NPIC_LOAD;
						end
					end
				end
				NPIC_LOAD: begin
					state <= NPIC_IDLE;
				end
				default: begin
					state <= NPIC_IDLE;
				end
			endcase
		end
	end

	assign push_en = (state == NPIC_PUSH);
	assign push_sel = push_cnt;
	assign service_busy = (state != NPIC_IDLE);

	// Vector address from source: maskable vectors step down by two
	always_ff @(posedge clk) begin
		if (reset) begin
			program_counter <= 16'h0000;
			take_irq <= 1'b0;
		end else begin
			take_irq <= 1'b0;
			if (state == NPIC_LOAD) begin
				take_irq <= 1'b1;
				case (sel_src)
					npic_pkg::SRC_RESET: program_counter <= npic_pkg::VEC_RESET;
					npic_pkg::SRC_TRAP: program_counter <= npic_pkg::VEC_TRAP;
					npic_pkg::SRC_TOP: program_counter <= npic_pkg::VEC_TOP;
					default: program_counter <= npic_pkg::VEC_TOP - {11'h0, sel_vec, 1'b0}; // R5
				endcase
			end
		end
	end

	// Condition register: entry, return and software loads
	always_ff @(posedge clk) begin
		if (reset) begin
			condition_code_reg <= npic_pkg::CC_RESET; // R13
		end else if (state == NPIC_LOAD) begin
			condition_code_reg[npic_pkg::LEVEL_BIT_UPPER_POS] <= sel_code[1]; // R1 R4
			condition_code_reg[npic_pkg::LEVEL_BIT_LOWER_POS] <= sel_code[0];
		end else if (return_from_isr) begin
			condition_code_reg <= stack_cc; // R6
		end else if (cc_sw_load) begin
			condition_code_reg <= cc_sw_value;
		end
	end
	assign cur_code = {condition_code_reg[npic_pkg::LEVEL_BIT_UPPER_POS],
		condition_code_reg[npic_pkg::LEVEL_BIT_LOWER_POS]};

	// Wake: any request ends wait, only capable ones end halt
	always_comb begin
		wake = 1'b0;
		if (reset_pend || trap_pend || top_pend) begin
			wake = 1'b1; // R11
		end else if (wait_mode && |pend) begin
			wake = 1'b1; // R20
		end else if (halt_mode && |(pend & HALT_WAKE)) begin
			wake = 1'b1; // R20
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	chk_reset_skip: assert property (@(posedge clk) disable iff (reset) // R10
		entering && next_src == npic_pkg::SRC_RESET |=> state == NPIC_LOAD)
		else $error("reset entry stacked");
	chk_stack_five: assert property (@(posedge clk) disable iff (reset) // R3
		state == NPIC_PUSH && push_ready && push_cnt == 3'h4 |=> state == NPIC_LOAD)
		else $error("stack count wrong");
	chk_level_load: assert property (@(posedge clk) disable iff (reset) // R4
		state == NPIC_LOAD |=> cur_code == $past(sel_code))
		else $error("level not loaded");
	chk_nmi_level: assert property (@(posedge clk) disable iff (reset) // R10
		state == NPIC_LOAD && sel_src != npic_pkg::SRC_MASK |=> cur_code == npic_pkg::LVL3_CODE)
		else $error("nmi level not 3");
	chk_vec_take: assert property (@(posedge clk) disable iff (reset) // R5
		state == NPIC_LOAD |=> take_irq && program_counter[15:5] == 11'h7ff)
		else $error("vector not loaded");
	chk_boundary: assert property (@(posedge clk) disable iff (reset) // R2
		state == NPIC_IDLE && !instr_boundary |=> state == NPIC_IDLE)
		else $error("entry off boundary");
	chk_mask_lvl: assert property (@(posedge clk) disable iff (reset) // R14
		entering && next_src == npic_pkg::SRC_MASK |-> code_rank(best_code) > cur_rank)
		else $error("masked request taken");
	chk_return_cc: assert property (@(posedge clk) disable iff (reset) // R6
		return_from_isr && state != NPIC_LOAD |=> condition_code_reg == $past(stack_cc))
		else $error("return not restored");
	chk_lvl0_write: assert property (@(posedge clk) disable iff (reset) // R23
		wr && addr == npic_pkg::LEVEL_REG0 && wdata[1:0] == npic_pkg::LVL0_CODE
		|=> vector_level_regs[0][1:0] == $past(vector_level_regs[0][1:0]))
		else $error("level0 written");
	cov_reset_entry: cover property (@(posedge clk) state == NPIC_LOAD && sel_src == npic_pkg::SRC_RESET);
	cov_trap_entry: cover property (@(posedge clk) state == NPIC_LOAD && sel_src == npic_pkg::SRC_TRAP);
	cov_mask_entry: cover property (@(posedge clk) state == NPIC_LOAD && sel_src == npic_pkg::SRC_MASK);
endmodule

// *** test/npic_cpu_model.sv ***
`timescale 1ns/100ps
// ****************
// CPU sequencer stand-in
// ****************
module npic_cpu_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic slow,
	input wire logic ret_cmd,
	input wire logic push_en,
	input wire logic [2:0] push_sel,
	input wire logic [7:0] condition_code_reg,
	output logic instr_boundary,
	output logic push_ready,
	output logic return_from_isr,
	output logic [7:0] stack_cc
);
	logic [7:0] stk [$];
	integer seed = 27;
	// Known levels before the first edge
	initial begin
		instr_boundary = 1'b1;
		push_ready = 1'b1;
		return_from_isr = 1'b0;
		stack_cc = 8'h00;
	end
	// A busy core stalls boundaries and stack slots at random
	always @(posedge clk) begin
		instr_boundary <= reset || !slow || $random(seed) % 2 == 0;
		push_ready <= reset || !slow || $random(seed) % 3 != 0;
	end
	// Stack of condition bytes; the value is scrambled once released
	always @(posedge clk) begin
		return_from_isr <= 1'b0;
		stack_cc <= ~stack_cc;
		if (reset) begin
			stk.delete();
		end else if (ret_cmd && stk.size() != 0) begin
			return_from_isr <= 1'b1;
			stack_cc <= stk.pop_back();
		end
		if (!reset && push_en && push_ready && push_sel == 3'h4) begin
			stk.push_back(condition_code_reg);
		end
	end
endmodule

// *** test/test_nested_priority_interrupt_ctrl.sv ***
`timescale 1ns/100ps
// ****************
// Bench top
// ****************
module test_nested_priority_interrupt_ctrl;
	logic clk, reset = 1'b1, wr = 1'b0, rd = 1'b0, pin = 1'b0, trap_exec = 1'b0;
	logic cc_sw_load = 1'b0, halt_mode = 1'b0, slow = 1'b0, ret_cmd = 1'b0, rd_seen = 1'b0;
	logic instr_boundary, return_from_isr, push_ready, take_irq, push_en, wake;
	logic wait_mode = 1'b0, top_rise = 1'b1, busy;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00, cc_sw_value = 8'h00, rdata, stack_cc, cc, old, d;
	logic [3:0] ext_pin [4] = '{default: 4'h0};
	logic [3:0] ext_pin_en [4] = '{4'h3, 4'h0, 4'h0, 4'h0};
	logic [13:0] periph_flag = 14'h0, periph_en = 14'h0, periph_clear = 14'h0;
	logic [15:0] program_counter;
	logic [2:0] push_sel, pushes = 3'h0;
	logic [20:0] iq [$];
	logic [7:0] rq [$];
	int fails = 0, checked = 0, irq_seen = 0, seed = 27;

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	npic_ctrl i_npic_ctrl (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .top_level_pin_irq(pin), .top_edge_rising(top_rise),
		.ext_pin(ext_pin), .ext_pin_en(ext_pin_en), .ext_irq_sensitivity_ctrl(5'h0f),
		.periph_flag(periph_flag), .periph_en(periph_en), .periph_clear(periph_clear),
		.instr_boundary(instr_boundary), .trap_exec(trap_exec),
		.return_from_isr(return_from_isr), .stack_cc(stack_cc), .cc_sw_load(cc_sw_load),
		.cc_sw_value(cc_sw_value), .push_ready(push_ready), .wait_mode(wait_mode),
		.halt_mode(halt_mode), .condition_code_reg(cc), .take_irq(take_irq),
		.program_counter(program_counter), .push_en(push_en), .push_sel(push_sel),
		.service_busy(busy), .wake(wake));

	npic_cpu_model i_npic_cpu_model (.clk(clk), .reset(reset), .slow(slow), .ret_cmd(ret_cmd),
		.push_en(push_en), .push_sel(push_sel), .condition_code_reg(cc),
		.instr_boundary(instr_boundary), .push_ready(push_ready),
		.return_from_isr(return_from_isr), .stack_cc(stack_cc));

	// ****************
	// Tasks
	// ****************
	task check(input logic [20:0] seen, input logic [20:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task print_verdict;
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task wr_reg(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task rd_reg(input logic [1:0] a, input logic [7:0] exp);
		rq.push_back(exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask

	task sw_cc(input logic [7:0] v);
		@(posedge clk);
		cc_sw_value <= v;
		cc_sw_load <= 1'b1;
		@(posedge clk);
		cc_sw_load <= 1'b0;
	endtask

	task expect_irq(input logic [15:0] pc, input logic [1:0] lvl);
		iq.push_back({pc, lvl, npic_pkg::STACK_BYTES});
	endtask

	// Bounded wait for the next entry seen by the monitor
	task wait_irq;
		int n;
		n = irq_seen;
		for (int k = 0; k < 80 && irq_seen == n; k++) @(posedge clk);
		if (irq_seen == n) check(21'h1, 21'h0);
	endtask

	// Spend a while in the routine so wrong preemption shows, then return
	task ret(input logic [1:0] lvl);
		repeat (4) @(posedge clk);
		ret_cmd <= 1'b1;
		@(posedge clk);
		ret_cmd <= 1'b0;
		repeat (2) @(negedge clk);
		check({19'h0, cc[5], cc[3]}, {19'h0, lvl});
		@(posedge clk);
	endtask

	// ****************
	// Monitor: results against the oldest note
	// ****************
	always @(posedge clk) begin
		rd_seen <= rd;
		if (rd_seen) begin
			if (rq.size() == 0) check(21'h1, 21'h0);
			else check({13'h0, rdata}, {13'h0, rq.pop_front()});
		end
		if (take_irq) begin
			irq_seen <= irq_seen + 1;
			pushes <= 3'h0;
			// An entry nobody asked for is a fault as well
			if (iq.size() == 0) check(21'h1, 21'h0);
			else check({program_counter, cc[5], cc[3], pushes}, iq.pop_front());
		end else if (push_en && push_ready) begin
			check({17'h0, busy, push_sel}, {17'h0, 1'b1, pushes});
			pushes <= pushes + 3'h1;
		end
	end

	// Watchdog, well beyond the expected run
	initial begin
		#500000;
		fails++;
		print_verdict;
	end

	// ****************
	// Main sequence
	// ****************
	initial begin
		iq.push_back({npic_pkg::VEC_RESET, npic_pkg::LVL3_CODE, 3'h0});
		@(posedge clk);
		@(negedge clk);
		check({13'h0, cc}, {13'h0, npic_pkg::CC_RESET});
		@(posedge clk);
		reset <= 1'b0;
		wait_irq;
		wr_reg(2'h0, 8'hd7);
		wr_reg(2'h1, 8'h3f);
		wr_reg(2'h3, 8'h00);
		rd_reg(2'h3, 8'hf0);
		wr_reg(2'h3, 8'h05);
		rd_reg(2'h0, 8'hd7);
		rd_reg(2'h1, 8'h3f);
		rd_reg(2'h3, 8'hf5);
		wr_reg(2'h2, 8'hcf);
		wr_reg(2'h2, 8'h64);
		rd_reg(2'h2, 8'h44);
		old = 8'h44;
		repeat (6) begin
			d = $random(seed);
			wr_reg(2'h2, d);
			for (int f = 0; f < 8; f += 2)
				if (d[f+:2] != npic_pkg::LVL0_CODE) old[f+:2] = d[f+:2];
			rd_reg(2'h2, old);
		end
		wr_reg(2'h2, 8'hff);
		// Trap at level 3, then the top pin preempts it
		expect_irq(npic_pkg::VEC_TRAP, npic_pkg::LVL3_CODE);
		@(posedge clk);
		trap_exec <= 1'b1;
		@(posedge clk);
		trap_exec <= 1'b0;
		wait_irq;
		expect_irq(npic_pkg::VEC_TOP, npic_pkg::LVL3_CODE);
		pin <= 1'b1;
		wait_irq;
		ret(npic_pkg::LVL3_CODE);
		ret(npic_pkg::LVL3_CODE);
		sw_cc(8'h20);
		periph_en <= 14'h3bff;
		periph_flag[10] <= 1'b1;
		repeat (20) @(posedge clk);
		periph_flag[10] <= 1'b0;
		// Software level first, hardware order breaks ties; core stalls
		slow <= 1'b1;
		expect_irq(16'hffec, npic_pkg::LVL2_CODE);
		periph_flag <= 14'h2082;
		wait_irq;
		periph_flag[7] <= 1'b0;
		expect_irq(16'hfff8, npic_pkg::LVL1_CODE);
		ret(npic_pkg::LVL0_CODE);
		wait_irq;
		periph_flag[1] <= 1'b0;
		expect_irq(16'hffe0, npic_pkg::LVL1_CODE);
		ret(npic_pkg::LVL0_CODE);
		wait_irq;
		periph_flag[13] <= 1'b0;
		ret(npic_pkg::LVL0_CODE);
		slow <= 1'b0;
		// Halt: a non-waking source waits behind a pin edge
		halt_mode <= 1'b1;
		periph_flag[8] <= 1'b1;
		repeat (10) @(negedge clk);
		check({20'h0, wake}, 21'h0);
		// Wait mode is ended by any pending request, capable or not
		@(posedge clk);
		wait_mode <= 1'b1;
		@(negedge clk);
		check({20'h0, wake}, 21'h1);
		@(posedge clk);
		wait_mode <= 1'b0;
		expect_irq(16'hfff6, npic_pkg::LVL1_CODE);
		expect_irq(16'hffea, npic_pkg::LVL3_CODE);
		@(posedge clk);
		ext_pin[0][1] <= 1'b1;
		wait_irq;
		halt_mode <= 1'b0;
		wait_irq;
		periph_flag[8] <= 1'b0;
		ret(npic_pkg::LVL1_CODE);
		ret(npic_pkg::LVL0_CODE);
		// Falling edge selected: the pin release must now raise the top request
		top_rise <= 1'b0;
		pin <= 1'b0;
		expect_irq(npic_pkg::VEC_TOP, npic_pkg::LVL3_CODE);
		wait_irq;
		ret(npic_pkg::LVL0_CODE);
		repeat (20) @(posedge clk);
		print_verdict;
	end
endmodule
